// ---- src/timer16_rtc.sv ----
// sixteen_bit_timer with secondary oscillator, special event and apb
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "timer16_defs.svh"

module timer16_rtc
(
    // apb clock and power-on reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    // other resets and power state
    input  wire logic                   soft_reset,
    input  wire logic                   sleep_mode,
    // pins
    input  wire logic                   ext_clk_pin,
    input  wire logic                   crystal_in_pin,
    output logic                        crystal_out_pin,
    // compare unit and converter
    input  wire timer16_pkg::cmp_mode_t compare_mode_field,
    input  wire timer16_pkg::byte_t     compare_value_high,
    input  wire timer16_pkg::byte_t     compare_value_low,
    input  wire logic                   adc_enable,
    output logic                        adc_start,
    // interrupt
    output logic                        irq
);
    import timer16_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]         ctrl_r;      // timer_control_reg
    byte_t              cnt_hi_r;    // count_high_byte
    byte_t              cnt_lo_r;    // count_low_byte
    logic [`IRQ_W-1:0]  flag_r;      // periph_irq_flag_reg
    logic [`IRQ_W-1:0]  en_r;        // periph_irq_enable_reg
    logic [2:0]         div_r;       // internal divide by four
    logic               src_d_r;     // delayed external level
    logic               armed_r;     // falling edge seen since enable
    logic               match_d_r;   // match seen last cycle
    logic               sev_r;       // trigger clears next cycle
    count_t             cnt_nxt;     // next count value

    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------
    wire       timer_on            = ctrl_r[`CTRL_ON_BIT];
    wire       clock_source_select = ctrl_r[`CTRL_CS_BIT];
    wire       sync_bypass_bit     = ctrl_r[`CTRL_SYNC_BIT];
    wire       sec_osc_enable      = ctrl_r[`CTRL_OSC_BIT];
    prescale_t ps_sel;
    assign ps_sel = ctrl_r[`CTRL_PS_MSB:`CTRL_PS_LSB];

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic xtal_s;   // crystal input, synchronised
    logic ext_s;    // external clock, synchronised

    sync2 u_sync_xtal
    (
        .pclk    (pclk),
        .presetn (presetn),
        .d_in    (crystal_in_pin),
        .q_out   (xtal_s)
    );

    sync2 u_sync_ext
    (
        .pclk    (pclk),
        .presetn (presetn),
        .d_in    (ext_clk_pin),
        .q_out   (ext_s)
    );

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire sel_ctrl  = paddr == `OFS_CTRL;
    wire sel_lo    = paddr == `OFS_COUNT_LO;
    wire sel_hi    = paddr == `OFS_COUNT_HI;
    wire sel_flag  = paddr == `OFS_IRQ_FLAG;
    wire sel_en    = paddr == `OFS_IRQ_EN;
    wire mapped    = sel_ctrl | sel_lo | sel_hi | sel_flag | sel_en;
    // unmapped addresses answer with an error and change nothing
    wire setup     = psel & ~penable & ~pready;
    // write lands only at the completing edge of a mapped access
    wire wr_go     = psel & penable & pready & pwrite & mapped;
    wire wr_ctrl   = wr_go & sel_ctrl;
    wire wr_lo     = wr_go & sel_lo;
    wire wr_hi     = wr_go & sel_hi;
    wire wr_flag   = wr_go & sel_flag;
    wire wr_en     = wr_go & sel_en;
    wire wr_count  = wr_lo | wr_hi;

    // ------------------------------------------------------------------
    // clock source and ticks
    // ------------------------------------------------------------------
    // crystal pin feeds the counter when the oscillator is on
    // pin edges arrive two cycles late through the synchroniser,
    // fine for watch rates but not for fast external clocks
    wire src_lvl   = sec_osc_enable ? xtal_s : ext_s;
    wire src_rise  = src_lvl & ~src_d_r;
    wire src_fall  = ~src_lvl & src_d_r;
    // internal clock stops in sleep like the instruction clock
    wire int_tick  = (div_r == `INT_DIV - 3'h1) & ~sleep_mode;
    wire ext_tick  = src_rise & armed_r;
    wire raw_tick  = clock_source_select ? ext_tick : int_tick;
    // synced counter mode halts in sleep, prescaler keeps going
    wire halt_slp  = sleep_mode & clock_source_select
                     & ~sync_bypass_bit;
    wire ps_tick;

    // ------------------------------------------------------------------
    // special event trigger from the compare match
    // ------------------------------------------------------------------
    count_t cnt_cur;
    count_t cmp_val;
    assign cnt_cur = {cnt_hi_r, cnt_lo_r};
    assign cmp_val = {compare_value_high, compare_value_low};
    // one trigger per match, so a held match clears only once
    wire match     = (compare_mode_field == `SEV_MODE)
                     & (cnt_cur == cmp_val) & timer_on;
    // registered trigger: count clears two cycles after the match,
    // so the compare value is the last count of each period
    wire sev_fire  = match & ~match_d_r;

    // prescaler cleared by count writes and by the trigger
    wire ps_clr    = wr_count | sev_r | ~timer_on;

    tmr_prescaler #(.PS_W(3)) u_pre
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .clr      (ps_clr),
        .sel      (ps_sel),
        .tick_in  (raw_tick),
        .tick_out (ps_tick)
    );

    wire inc       = ps_tick & timer_on & ~halt_slp;
    wire ovf       = inc & (cnt_cur == `COUNT_MAX) & ~wr_count
                     & ~sev_r;

    // ------------------------------------------------------------------
    // next count: write, then trigger, then increment
    // ------------------------------------------------------------------
    always_comb
    begin
        cnt_nxt = cnt_cur;
        if (wr_count)
        begin
            // a write beats a trigger landing in the same cycle
            if (wr_lo)
                cnt_nxt[7:0] = pwdata[7:0];
            if (wr_hi)
                cnt_nxt[15:8] = pwdata[7:0];
        end
        else if (sev_r)
            cnt_nxt = '0;
        else if (inc)
            cnt_nxt = cnt_cur + 16'h0001;
    end

    // ------------------------------------------------------------------
    // count bytes: no reset term, contents survive every reset
    // ------------------------------------------------------------------
    // unknown after power-up until a write or a trigger
    always_ff @(posedge pclk)
    begin
        cnt_hi_r <= cnt_nxt[15:8];
        cnt_lo_r <= cnt_nxt[7:0];
    end

    // ------------------------------------------------------------------
    // control register: only the power reset clears it
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_r <= `CTRL_RST;
        else if (wr_ctrl)
            // bits 7:6 are unused and always read back as zero
            ctrl_r <= {2'b00, pwdata[5:0]};
    end

    // ------------------------------------------------------------------
    // edge tracking, divider and trigger pipeline
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_r     <= 3'h0;
            src_d_r   <= 1'b0;
            armed_r   <= 1'b0;
            match_d_r <= 1'b0;
            sev_r     <= 1'b0;
        end
        else
        begin
            div_r     <= (div_r == `INT_DIV - 3'h1) ? 3'h0
                         : div_r + 3'h1;
            src_d_r   <= src_lvl;
            // counting waits for a falling edge after enabling
            if (!timer_on || !clock_source_select)
                armed_r <= 1'b0;
            else if (src_fall)
                armed_r <= 1'b1;
            match_d_r <= match;
            sev_r     <= sev_fire;
        end
    end

    // ------------------------------------------------------------------
    // interrupt flags and enables: set wins over clear
    // ------------------------------------------------------------------
    logic [`IRQ_W-1:0] ev_set;   // events this cycle
    logic [`IRQ_W-1:0] clr_bits; // write-one-to-clear bits
    // bit 0 overflow, bit 1 special event trigger
    assign ev_set   = {sev_r, ovf};
    assign clr_bits = wr_flag ? pwdata[`IRQ_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_r <= '0;
            en_r   <= '0;
            irq    <= 1'b0;
        end
        else if (soft_reset)
        begin
            // other resets clear flags and enables, not control
            flag_r <= ev_set;
            en_r   <= '0;
            irq    <= 1'b0;
        end
        else
        begin
            flag_r <= (flag_r & ~clr_bits) | ev_set;
            if (wr_en)
                en_r <= pwdata[`IRQ_W-1:0];
            // level irq, not gated by sleep so it can wake
            irq    <= |(flag_r & en_r);
        end
    end

    // ------------------------------------------------------------------
    // oscillator amplifier and converter start
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            crystal_out_pin <= 1'b0;
            adc_start       <= 1'b0;
        end
        else
        begin
            // inverting stage only while enabled, sleep ignored
            // a registered inverter stands in for the analog stage,
            // so the loop period is set by the pin round trip
            crystal_out_pin <= sec_osc_enable & ~xtal_s;
            adc_start       <= sev_fire & adc_enable;
        end
    end

    // ------------------------------------------------------------------
    // apb read mux
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (sel_ctrl)
            rd_mux[7:0] = ctrl_r;
        else if (sel_lo)
            rd_mux[7:0] = cnt_lo_r;
        else if (sel_hi)
            rd_mux[7:0] = cnt_hi_r;
        else if (sel_flag)
            rd_mux[`IRQ_W-1:0] = flag_r;
        else if (sel_en)
            rd_mux[`IRQ_W-1:0] = en_r;
    end

    // ------------------------------------------------------------------
    // apb answer: ready in the first cycle of the access phase
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        // fixed single access cycle, never stretched
        else if (setup)
        begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~mapped;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule : timer16_rtc
`default_nettype wire

// ---- common/timer16_defs.svh ----
// offsets, field positions, reset values and counts of the timer block
`ifndef TIMER16_DEFS_SVH
`define TIMER16_DEFS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL        12'h000
`define OFS_COUNT_LO    12'h004
`define OFS_COUNT_HI    12'h008
`define OFS_IRQ_FLAG    12'h00c
`define OFS_IRQ_EN      12'h010

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define CTRL_ON_BIT     0
`define CTRL_CS_BIT     1
`define CTRL_SYNC_BIT   2
`define CTRL_OSC_BIT    3
`define CTRL_PS_LSB     4
`define CTRL_PS_MSB     5
`define CTRL_RST        8'h00

// ----------------------------------------------------------------------
// interrupt fields and other constants
// ----------------------------------------------------------------------
`define IRQ_OVF_BIT     0
`define IRQ_SEV_BIT     1
`define IRQ_W           2
`define SEV_MODE        4'hb
`define INT_DIV         3'h4
`define COUNT_MAX       16'hffff

`endif

// ---- common/timer16_pkg.sv ----
// types shared by the timer block
package timer16_pkg;
    typedef logic [15:0] count_t;     // full timer count
    typedef logic [7:0]  byte_t;      // one count byte
    typedef logic [3:0]  cmp_mode_t;  // compare unit mode field
    typedef logic [1:0]  prescale_t;  // prescale select
endpackage : timer16_pkg

// ---- src/sync2.sv ----
// two flip-flop synchroniser for a pin level
`timescale 1ns/10ps
`default_nettype none
module sync2
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // level in and out
    input  wire logic d_in,
    output logic      q_out
);
    logic meta_r;  // first stage, read by the second only

    // ------------------------------------------------------------------
    // two stages
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_r <= 1'b0;
            q_out  <= 1'b0;
        end
        else
        begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule : sync2
`default_nettype wire

// ---- src/tmr_prescaler.sv ----
// ripple style prescaler: 1, 2, 4 or 8 input ticks per output tick
`timescale 1ns/10ps
`default_nettype none
module tmr_prescaler
#(
    parameter int PS_W = 3  // counter width, 2**PS_W is largest ratio
)
(
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // control
    input  wire logic                  clr,
    input  wire timer16_pkg::prescale_t sel,
    // ticks
    input  wire logic                  tick_in,
    output logic                       tick_out
);
    import timer16_pkg::*;

    // elaboration check: the select decode assumes three bits
    if (PS_W != 3)
    begin : g_bad_width
        $error("prescaler width must be 3");
    end

    logic [PS_W-1:0] cnt_r;   // prescale counter
    logic [PS_W-1:0] mask;    // bits that must be all ones
    logic            full;    // last tick of the ratio

    assign mask = (PS_W'(1) << sel) - PS_W'(1);
    assign full = (cnt_r & mask) == mask;

    // ------------------------------------------------------------------
    // count input ticks, clear wins over counting
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r    <= '0;
            tick_out <= 1'b0;
        end
        else if (clr)
        begin
            cnt_r    <= '0;
            tick_out <= 1'b0;
        end
        else
        begin
            tick_out <= tick_in & full;
            if (tick_in)
                cnt_r <= full ? '0 : cnt_r + PS_W'(1);
        end
    end
endmodule : tmr_prescaler
`default_nettype wire

// ---- tb/timer16_rtc_asserts.sv ----
// port assertions for the timer block
`timescale 1ns/10ps
`default_nettype none
module timer16_rtc_asserts
(
    // clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // apb handshake
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // other resets and pins
    input wire logic                   soft_reset,
    input wire logic                   crystal_in_pin,
    input wire logic                   crystal_out_pin,
    // compare unit, converter, interrupt
    input wire timer16_pkg::cmp_mode_t compare_mode_field,
    input wire logic                   adc_enable,
    input wire logic                   adc_start,
    input wire logic                   irq
);
    import timer16_pkg::*;
    // ------------------------------------------------------------
    // single domain: one clock, power reset disables all
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // setup is answered in the very next cycle
    property p_answer;
        psel && !penable |=> pready && penable;
    endproperty
    a_answer: assert property (p_answer)
        else $error("no answer after setup");

    // answer stands one cycle only
    property p_one_cycle;
        pready |=> !pready;
    endproperty
    a_one_cycle: assert property (p_one_cycle)
        else $error("pready held too long");

    // error only rides on an answer
    property p_err_rdy;
        pslverr |-> pready;
    endproperty
    a_err_rdy: assert property (p_err_rdy)
        else $error("pslverr without pready");

    // outputs quiet right after power reset
    property p_quiet;
        $rose(presetn) |-> !irq && !adc_start && !crystal_out_pin;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("outputs active after reset");

    // amplifier output is the inverted input, three cycles late
    property p_osc_loop;
        crystal_out_pin |-> !$past(crystal_in_pin, 3);
    endproperty
    a_osc_loop: assert property (p_osc_loop)
        else $error("oscillator output not inverted input");

    // irq only drops after software touched the bus or a reset
    property p_irq_sticky;
        irq && !psel && !$past(psel) && !soft_reset
            && !$past(soft_reset) |=> irq;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky)
        else $error("irq dropped by itself");

    // conversion start needs mode 1011 and an enabled converter
    property p_adc_cause;
        adc_start |-> $past(adc_enable)
            && $past(compare_mode_field) == 4'hb;
    endproperty
    a_adc_cause: assert property (p_adc_cause)
        else $error("conversion start without cause");

    // one trigger per match entry
    property p_adc_once;
        adc_start |=> !adc_start;
    endproperty
    a_adc_once: assert property (p_adc_once)
        else $error("conversion start longer than a cycle");
endmodule : timer16_rtc_asserts

bind timer16_rtc timer16_rtc_asserts u_chk
(
    .pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .soft_reset, .crystal_in_pin, .crystal_out_pin,
    .compare_mode_field, .adc_enable, .adc_start, .irq
);
`default_nettype wire

// ---- tb/xtal_clk_model.sv ----
// watch crystal and external clock source at the timer pins
`timescale 1ns/10ps
`default_nettype none
module xtal_clk_model
#(
    parameter int HALF = 6  // ext clock half period, pclk cycles
)
(
    // clock
    input  wire logic pclk,
    // crystal across the amplifier
    input  wire logic drive_out,
    output logic      fb_in,
    // external clock source
    input  wire logic ext_run,
    output logic      ext_clk
);
    int cnt;  // half period counter

    initial
    begin
        fb_in = 1'b0;
        ext_clk = 1'b0;
        cnt = 0;
    end

    // resonator: returns the amplifier output a cycle late
    always @(posedge pclk)
        fb_in <= drive_out;

    // source stands low between runs, so no stray edge
    always @(posedge pclk)
    begin
        if (!ext_run)
        begin
            cnt <= 0;
            ext_clk <= 1'b0;
        end
        else if (cnt == HALF - 1)
        begin
            cnt <= 0;
            ext_clk <= ~ext_clk;
        end
        else
            cnt <= cnt + 1;
    end
endmodule : xtal_clk_model
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the timer block
`timescale 1ns/10ps
`default_nettype none
`include "timer16_defs.svh"
module tb;
    import timer16_pkg::*;
    // ------------------------------------------------------------
    // signals, all dut inputs driven from time zero
    // ------------------------------------------------------------
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdata;
    logic        pready, pslverr, rerr, crystal_in_pin, crystal_out_pin;
    logic        soft_reset = 1'b0;
    logic        sleep_mode = 1'b0;
    logic        ext_run = 1'b0;
    logic        ext_clk_pin, adc_start, irq;
    cmp_mode_t   compare_mode_field = 4'h0;
    byte_t       compare_value_high = 8'h00;
    byte_t       compare_value_low = 8'h10;
    logic        adc_enable = 1'b1;
    logic [15:0] cnt;
    int          miscompares = 0;
    int          n_checks = 0;
    int          i;
    // reset rows: address, read value, error flag
    typedef struct {logic [11:0] a; logic [31:0] d; logic e;} row_t;
    row_t rows [5] = '{'{`OFS_CTRL, 32'h0, 1'b0},
        '{`OFS_IRQ_FLAG, 32'h0, 1'b0}, '{`OFS_IRQ_EN, 32'h0, 1'b0},
        '{12'h014, 32'h0, 1'b1}, '{12'hffc, 32'h0, 1'b1}};

    always #2.5 pclk = ~pclk;

    timer16_rtc dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .soft_reset, .sleep_mode,
        .ext_clk_pin, .crystal_in_pin, .crystal_out_pin,
        .compare_mode_field, .compare_value_high, .compare_value_low,
        .adc_enable, .adc_start, .irq);
    xtal_clk_model #(.HALF(6)) peer (.pclk, .drive_out(crystal_out_pin),
        .fb_in(crystal_in_pin), .ext_run, .ext_clk(ext_clk_pin));

    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task results;
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    task chk(input string nm, input logic [31:0] exp, got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // a wait that ran out ends the run
    task hang(input string nm);
        chk(nm, 32'h1, 32'h0);
        results();
    endtask : hang

    // one apb transfer, entered just after an edge
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++)
            @(posedge pclk);
        if (pready !== 1'b1)
            hang("pready");
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle cycle keeps two requests off one time step
        @(posedge pclk);
    endtask : xfer

    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task rd(input string nm, input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rdata);
    endtask : rd

    task setcnt(input logic [15:0] v);
        wr(`OFS_COUNT_LO, {24'h0, v[7:0]});
        wr(`OFS_COUNT_HI, {24'h0, v[15:8]});
    endtask : setcnt

    // run with a control value for n cycles, stop, read the count
    task run(input logic [7:0] c, input int n);
        wr(`OFS_CTRL, {24'h0, c});
        repeat (n) @(posedge pclk);
        wr(`OFS_CTRL, 32'h0);
        xfer(1'b0, `OFS_COUNT_LO, 32'h0);
        cnt[7:0] = rdata[7:0];
        xfer(1'b0, `OFS_COUNT_HI, 32'h0);
        cnt[15:8] = rdata[7:0];
    endtask : run

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[r])
        begin
            xfer(1'b0, rows[r].a, 32'h0);
            chk("rdata", rows[r].d, rdata);
            chk("pslverr", {31'h0, rows[r].e}, {31'h0, rerr});
        end
        // other resets keep control and count, power reset only count
        setcnt(16'h1234);
        wr(`OFS_CTRL, 32'h30);
        soft_reset <= 1'b1;
        @(posedge pclk);
        soft_reset <= 1'b0;
        @(posedge pclk);
        rd("ctrl kept", `OFS_CTRL, 32'h30);
        run(8'h00, 0);
        chk("count kept", 32'h1234, {16'h0, cnt});
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd("ctrl cleared", `OFS_CTRL, 32'h0);
        run(8'h00, 0);
        chk("count survives", 32'h1234, {16'h0, cnt});
        // internal rate at every prescale
        for (int p = 0; p < 4; p++)
        begin
            setcnt(16'h0);
            run(8'((p << 4) + 1), 128);
            chk("rate", 1, cnt >= (32 >> p) - 1
                && cnt <= (32 >> p) + 1);
        end
        // overflow sets a sticky flag, masked and cleared
        wr(`OFS_IRQ_EN, 32'h1);
        setcnt(16'hfffe);
        wr(`OFS_CTRL, 32'h1);
        for (i = 0; i < 40 && irq !== 1'b1; i++)
            @(posedge pclk);
        if (irq !== 1'b1)
            hang("irq");
        wr(`OFS_CTRL, 32'h0);
        rd("ovf flag", `OFS_IRQ_FLAG, 32'h1);
        chk("irq held", 1, irq);
        wr(`OFS_IRQ_EN, 32'h0);
        @(posedge pclk);
        chk("irq masked", 0, irq);
        wr(`OFS_IRQ_EN, 32'h1);
        @(posedge pclk);
        chk("irq unmasked", 1, irq);
        wr(`OFS_IRQ_FLAG, 32'h1);
        @(posedge pclk);
        chk("irq cleared", 0, irq);
        rd("flag cleared", `OFS_IRQ_FLAG, 32'h0);
        // handler preload: only the high byte is written, with its top bit set
        wr(`OFS_COUNT_HI, 32'h80);
        run(8'h00, 0);
        chk("preload", 32'h80, {24'h0, cnt[15:8]});
        // special event: compare value acts as period
        setcnt(16'h0);
        compare_mode_field <= 4'hb;
        wr(`OFS_CTRL, 32'h1);
        for (i = 0; i < 200 && adc_start !== 1'b1; i++)
            @(posedge pclk);
        if (adc_start !== 1'b1)
            hang("adc_start");
        @(posedge pclk);
        for (i = 0; i < 200 && adc_start !== 1'b1; i++)
            @(posedge pclk);
        if (adc_start !== 1'b1)
            hang("period");
        chk("period", 1, i >= 62 && i <= 72);
        run(8'h00, 0);
        chk("cleared", 1, cnt < 2);
        rd("event flag", `OFS_IRQ_FLAG, 32'h2);
        compare_mode_field <= 4'h0;
        // asynchronous external count keeps going in sleep
        setcnt(16'h0);
        sleep_mode <= 1'b1;
        ext_run <= 1'b1;
        run(8'h07, 240);
        chk("async sleep", 1, cnt >= 17 && cnt <= 21);
        // synchronised external count holds in sleep
        setcnt(16'h0);
        run(8'h03, 120);
        chk("sync sleep", 32'h0, {16'h0, cnt});
        // oscillator drives the count, still asleep
        chk("osc off", 0, crystal_out_pin);
        ext_run <= 1'b0;
        setcnt(16'h0);
        run(8'h0f, 200);
        chk("osc count", 1, cnt >= 20 && cnt <= 26);
        sleep_mode <= 1'b0;
        results();
    end
endmodule : tb
`default_nettype wire
